// >>> cme_consts.svh
// constants of the command-mode entry block: offsets, fields, resets, timing
// assumes it is included by the top module
// Notes on behaviour
// - the serial input must be silent for the lead guard time (100 ms units, 2..FFFF, default 0A)
// - command code 04 writes the lead guard time and a read returns it as two bytes
// - the escape character is held in range 20..7F with default 2B
// - from idle, lead silence then the escape character then trailing silence enter command mode
// - command code 13 writes the escape character and a read returns it as one byte
// - the indicator line follows its setting: 0 receive, 1 high, 2 low, 3 reserved, 4 own packets
// - command code 28 writes the indicator setting and a read returns one byte
// - exit command code 09 leaves command mode at once and returns to idle
// - the flow line gives CTS for 0, TX enable low for 1, high for 3, fixed high 2 and low 4
// - after reset the flow line provides CTS flow control
// - a non-standard serial rate is stored as the nearest achievable value
// - after the escape character the input must be silent for the trailing guard time (default 0A)
// - command mode ends by itself after the inactivity timeout (100 ms units, default C8)
// - a new serial rate takes effect only when the exit command is given
`ifndef CME_CONSTS_SVH
`define CME_CONSTS_SVH
`define CME_CLK_HZ        25000000
`define CME_TICK_MS       100
`define CME_OFF_CMD       8'h00
`define CME_OFF_RESP      8'h04
`define CME_OFF_STATUS    8'h08
`define CME_OFF_CONFIG    8'h0C
`define CME_CMD_WR_BIT    24
`define CME_OP_LEAD       8'h04
`define CME_OP_TRAIL      8'h05
`define CME_OP_TIMEOUT    8'h06
`define CME_OP_EXIT       8'h09
`define CME_OP_ESC        8'h13
`define CME_OP_RATE       8'h15
`define CME_OP_FLOW       8'h1F
`define CME_OP_IND        8'h28
`define CME_RST_GUARD     16'h000A
`define CME_RST_TIMEOUT   16'h00C8
`define CME_RST_ESC       8'h2B
`define CME_MIN_GUARD     16'h0002
`define CME_ESC_LO        8'h20
`define CME_ESC_HI        8'h7F
`define CME_RATE_STD_MAX  16'h0006
`define CME_RATE_NSTD_MIN 16'h007D
`define CME_RATE_ALT_STD  16'h0005
`define CME_RATE_300_IN   16'h012C
`define CME_RATE_300_OUT  16'h012B
`define CME_RATE_576_IN   16'hE100
`define CME_RATE_576_A    16'hE883
`define CME_RATE_576_B    16'hE10D
`define CME_RESP_OKAY     2'h0
`define CME_RESP_SLVERR   2'h2
`endif

// >>> cme_pkg.sv
// types shared by the command-mode entry block
// assumes cme_consts.svh sits in the include path
package cme_pkg;
  typedef enum logic [3:0] {
    CME_IDLE  = 4'b0001,
    CME_ARMED = 4'b0010,
    CME_TRAIL = 4'b0100,
    CME_CMD   = 4'b1000
  } cme_mode_type;

  typedef struct packed {
    logic [15:0] lead_guard_time;
    logic [15:0] trail_guard_time;
    logic [15:0] command_timeout;
    logic [7:0]  escape_char;
    logic [2:0]  rx_indicator_config;
    logic [2:0]  flow_config;
    logic [15:0] rate_pending;
    logic [15:0] rate_active;
  } cme_cfg_type;

  typedef struct packed {
    cme_mode_type mode;
    cme_cfg_type  cfg;
    logic [31:0]  pre;
    logic [15:0]  units;
    logic         aw_got;
    logic [7:0]   awaddr;
    logic         w_got;
    logic [31:0]  wdata;
    logic         w_full;
    logic         awready;
    logic         wready;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [31:0]  last_cmd;
    logic [31:0]  resp;
    logic         ind;
    logic         flow;
  } cme_regs_type;
endpackage : cme_pkg

// >>> cme_top.sv
// command-mode entry, configuration commands and output line control
// assumes bytes from the uart arrive as one-cycle strobes and an axi4-lite master
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "cme_consts.svh"

module cme_top
  import cme_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = (`CME_CLK_HZ / 1000) * `CME_TICK_MS,
  parameter bit          VARIANT_B   = 1'b0
)
(
  input  wire logic        aclk,                  // module clock
  input  wire logic        aresetn,               // sync reset, active low
  input  wire logic        awvalid,               // write address valid
  output var  logic        awready,               // write address ready
  input  wire logic [31:0] awaddr,                // write address
  input  wire logic [2:0]  awprot,                // unused
  input  wire logic        wvalid,                // write data valid
  output var  logic        wready,                // write data ready
  input  wire logic [31:0] wdata,                 // write data
  input  wire logic [3:0]  wstrb,                 // byte enables
  output var  logic        bvalid,                // write response valid
  input  wire logic        bready,                // write response ready
  output var  logic [1:0]  bresp,                 // write response
  input  wire logic        arvalid,               // read address valid
  output var  logic        arready,               // read address ready
  input  wire logic [31:0] araddr,                // read address
  input  wire logic [2:0]  arprot,                // unused
  output var  logic        rvalid,                // read data valid
  input  wire logic        rready,                // read data ready
  output var  logic [31:0] rdata,                 // read data
  output var  logic [1:0]  rresp,                 // read response
  input  wire logic        serial_input_line_vld, // byte seen on serial input
  input  wire logic [7:0]  serial_input_line_byte,// that byte
  input  wire logic        rx_active,             // radio receive in progress
  input  wire logic        rx_addr_match,         // packet is for this module
  input  wire logic        clear_to_send,         // host may send
  input  wire logic        tx_active,             // line transmit in progress
  output var  logic        indicator_output_line, // receive indicator pin
  output var  logic        flow_output_line,      // flow control pin
  output var  logic        command_mode,          // command mode active
  output var  logic [15:0] serial_rate_setting    // rate in effect
);

  cme_regs_type r_q;
  cme_regs_type r_d;

  // -------------------------------------------------------------------
  // serial rate rounding
  // -------------------------------------------------------------------
  function automatic logic [15:0] round_rate(input logic [15:0] p);
    logic [15:0] v;
    v = p;
    if (VARIANT_B && p == `CME_RATE_STD_MAX)
      v = `CME_RATE_ALT_STD;
    else if (p == `CME_RATE_300_IN)
      v = `CME_RATE_300_OUT;
    else if (p == `CME_RATE_576_IN)
      v = VARIANT_B ? `CME_RATE_576_B : `CME_RATE_576_A;
    return v;
  endfunction : round_rate

  function automatic logic guard_ok(input logic [15:0] p);
    return p >= `CME_MIN_GUARD;
  endfunction : guard_ok

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb
  begin
    logic        tick;
    logic        byte_in;
    logic        wr;
    logic        ok;
    logic [7:0]  op;
    logic [15:0] p;
    logic [15:0] val;
    logic [1:0]  nbytes;
    tick    = 1'b0;
    byte_in = serial_input_line_vld;
    wr      = 1'b0;
    ok      = 1'b0;
    op      = 8'h00;
    p       = 16'h0000;
    val     = 16'h0000;
    nbytes  = 2'h0;
    r_d     = r_q;

    // 100 ms tick and saturating count of whole ticks since last activity
    if (r_q.pre == TICK_CYCLES - 1)
    begin
      r_d.pre = 32'h0000_0000;
      tick    = 1'b1;
    end
    else
      r_d.pre = r_q.pre + 32'h0000_0001;
    if (tick && r_q.units != 16'hFFFF)
      r_d.units = r_q.units + 16'h0001;

    // restarting the prescaler makes every guard count whole ticks
    if (byte_in)
    begin
      r_d.pre   = 32'h0000_0000;
      r_d.units = 16'h0000;
    end

    // escape sequence tracking
    case (r_q.mode)
      CME_IDLE:
      begin
        if (!byte_in && r_q.units >= r_q.cfg.lead_guard_time)
          r_d.mode = CME_ARMED;
      end
      CME_ARMED:
      begin
        if (byte_in)
        begin
          if (serial_input_line_byte == r_q.cfg.escape_char)
            r_d.mode = CME_TRAIL;
          else
            r_d.mode = CME_IDLE;
        end
      end
      CME_TRAIL:
      begin
        if (byte_in)
          r_d.mode = CME_IDLE;
        else if (r_q.units >= r_q.cfg.trail_guard_time)
        begin
          r_d.mode  = CME_CMD;
          r_d.pre   = 32'h0000_0000;
          r_d.units = 16'h0000;
        end
      end
      CME_CMD:
      begin
        if (!byte_in && r_q.units >= r_q.cfg.command_timeout)
        begin
          r_d.mode  = CME_IDLE;
          r_d.units = 16'h0000;
        end
      end
      default:
        r_d.mode = CME_IDLE;
    endcase

    // -------------------------------------------------------------------
    // register bus: write address and data are taken in either order
    // -------------------------------------------------------------------
    if (awvalid && r_q.awready)
    begin
      r_d.aw_got = 1'b1;
      r_d.awaddr = awaddr[7:0];
    end
    if (wvalid && r_q.wready)
    begin
      r_d.w_got  = 1'b1;
      r_d.wdata  = wdata;
      // strobes travel with the data beat, so they are judged when it is taken
      r_d.w_full = (wstrb == 4'hF);
    end
    if (r_q.bvalid && bready)
      r_d.bvalid = 1'b0;

    if (r_q.aw_got && r_q.w_got && !r_q.bvalid)
    begin
      r_d.aw_got = 1'b0;
      r_d.w_got  = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp  = `CME_RESP_OKAY;
      if (r_q.awaddr == `CME_OFF_CMD && r_q.w_full)
      begin
        op = r_q.wdata[23:16];
        p  = r_q.wdata[15:0];
        wr = r_q.wdata[`CME_CMD_WR_BIT];
        r_d.last_cmd = r_q.wdata;
        // commands are honoured in command mode only
        if (r_q.mode == CME_CMD && r_d.mode == CME_CMD)
        begin
          r_d.pre   = 32'h0000_0000;
          r_d.units = 16'h0000;
          ok        = 1'b1;
          case (op)
            `CME_OP_LEAD:
            begin
              nbytes = 2'h2;
              ok     = !wr || guard_ok(p);
              if (wr && ok)
                r_d.cfg.lead_guard_time = p;
              val = r_d.cfg.lead_guard_time;
            end
            `CME_OP_TRAIL:
            begin
              nbytes = 2'h2;
              ok     = !wr || guard_ok(p);
              if (wr && ok)
                r_d.cfg.trail_guard_time = p;
              val = r_d.cfg.trail_guard_time;
            end
            `CME_OP_TIMEOUT:
            begin
              nbytes = 2'h2;
              ok     = !wr || guard_ok(p);
              if (wr && ok)
                r_d.cfg.command_timeout = p;
              val = r_d.cfg.command_timeout;
            end
            `CME_OP_ESC:
            begin
              nbytes = 2'h1;
              ok     = !wr || (p >= {8'h00, `CME_ESC_LO} && p <= {8'h00, `CME_ESC_HI});
              if (wr && ok)
                r_d.cfg.escape_char = p[7:0];
              val = {8'h00, r_d.cfg.escape_char};
            end
            `CME_OP_IND:
            begin
              nbytes = 2'h1;
              ok     = !wr || p <= 16'h0004;
              if (wr && ok)
                r_d.cfg.rx_indicator_config = p[2:0];
              val = {13'h0000, r_d.cfg.rx_indicator_config};
            end
            `CME_OP_FLOW:
            begin
              nbytes = 2'h1;
              ok     = !wr || p <= 16'h0004;
              if (wr && ok)
                r_d.cfg.flow_config = p[2:0];
              val = {13'h0000, r_d.cfg.flow_config};
            end
            `CME_OP_RATE:
            begin
              nbytes = 2'h2;
              ok     = !wr || p <= `CME_RATE_STD_MAX || p >= `CME_RATE_NSTD_MIN;
              if (wr && ok)
                r_d.cfg.rate_pending = round_rate(p);
              val = r_d.cfg.rate_pending;
            end
            `CME_OP_EXIT:
            begin
              r_d.mode             = CME_IDLE;
              r_d.units            = 16'h0000;
              r_d.cfg.rate_active  = r_q.cfg.rate_pending;
            end
            default:
              ok = 1'b0;
          endcase
        end
        r_d.resp = {13'h0000, !ok, nbytes, val};
      end
      else
        r_d.bresp = `CME_RESP_SLVERR;
    end

    // -------------------------------------------------------------------
    // register bus: read channel
    // -------------------------------------------------------------------
    if (r_q.rvalid && rready)
      r_d.rvalid = 1'b0;
    if (arvalid && r_q.arready)
    begin
      r_d.rvalid = 1'b1;
      r_d.rresp  = `CME_RESP_OKAY;
      case (araddr[7:0])
        `CME_OFF_CMD:    r_d.rdata = r_q.last_cmd;
        `CME_OFF_RESP:   r_d.rdata = r_q.resp;
        `CME_OFF_STATUS: r_d.rdata = {r_q.cfg.rate_active, r_q.units[11:0], r_q.mode};
        `CME_OFF_CONFIG: r_d.rdata = {r_q.cfg.escape_char, 2'h0, r_q.cfg.flow_config,
                                      r_q.cfg.rx_indicator_config, r_q.cfg.rate_pending};
        default:
        begin
          r_d.rdata = 32'h0000_0000;
          r_d.rresp = `CME_RESP_SLVERR;
        end
      endcase
    end
    r_d.awready = !r_d.aw_got && !r_d.bvalid;
    r_d.wready  = !r_d.w_got && !r_d.bvalid;
    r_d.arready = !r_d.rvalid;

    // -------------------------------------------------------------------
    // output lines
    // -------------------------------------------------------------------
    // the reserved indicator setting falls into the default and drives low
    case (r_q.cfg.rx_indicator_config)
      3'h0:    r_d.ind = rx_active;
      3'h1:    r_d.ind = 1'b1;
      3'h4:    r_d.ind = rx_active && rx_addr_match;
      default: r_d.ind = 1'b0;
    endcase
    case (r_q.cfg.flow_config)
      3'h0:    r_d.flow = !clear_to_send;
      3'h1:    r_d.flow = !tx_active;
      3'h2:    r_d.flow = 1'b1;
      3'h3:    r_d.flow = tx_active;
      default: r_d.flow = 1'b0;
    endcase
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_q                          <= '0;
      r_q.mode                     <= CME_IDLE;
      r_q.cfg.lead_guard_time      <= `CME_RST_GUARD;
      r_q.cfg.trail_guard_time     <= `CME_RST_GUARD;
      r_q.cfg.command_timeout      <= `CME_RST_TIMEOUT;
      r_q.cfg.escape_char          <= `CME_RST_ESC;
      r_q.cfg.rx_indicator_config  <= 3'h0;
      r_q.cfg.flow_config          <= 3'h0;
      r_q.awready                  <= 1'b1;
      r_q.wready                   <= 1'b1;
      r_q.arready                  <= 1'b1;
      r_q.flow                     <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  assign awready               = r_q.awready;
  assign wready                = r_q.wready;
  assign bvalid                = r_q.bvalid;
  assign bresp                 = r_q.bresp;
  assign arready               = r_q.arready;
  assign rvalid                = r_q.rvalid;
  assign rdata                 = r_q.rdata;
  assign rresp                 = r_q.rresp;
  assign indicator_output_line = r_q.ind;
  assign flow_output_line      = r_q.flow;
  assign command_mode          = r_q.mode[3];
  assign serial_rate_setting   = r_q.cfg.rate_active;

endmodule : cme_top
`default_nettype wire

// >>> cme_top_asserts.sv
// port checks for the command-mode entry block
// assumes binding to cme_top with the same tick parameter
`timescale 1ns/100ps
`default_nettype none

module cme_top_asserts
#(
  parameter int unsigned TICK_CYCLES = 4
)
(
  input wire logic        aclk,                  // clock
  input wire logic        aresetn,               // sync reset
  input wire logic        awvalid,               // aw valid
  input wire logic        awready,               // aw ready
  input wire logic        wvalid,                // w valid
  input wire logic        wready,                // w ready
  input wire logic        bvalid,                // b valid
  input wire logic        bready,                // b ready
  input wire logic        arvalid,               // ar valid
  input wire logic        arready,               // ar ready
  input wire logic        rvalid,                // r valid
  input wire logic        rready,                // r ready
  input wire logic        serial_input_line_vld, // byte strobe
  input wire logic        command_mode,          // mode flag
  input wire logic        flow_output_line,      // flow pin
  input wire logic [15:0] serial_rate_setting    // rate in effect
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // cycles since the last byte; saturates so a long idle never wraps to zero
  logic [31:0] quiet_q;
  logic [31:0] quiet_d;

  always_comb
  begin
    quiet_d = quiet_q;
    if (serial_input_line_vld)
      quiet_d = 32'h00000000;
    else if (quiet_q != 32'hFFFFFFFF)
      quiet_d = quiet_q + 32'h00000001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      quiet_q <= 32'h00000000;
    else
      quiet_q <= quiet_d;
  end

  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence

  property p_reset_state;
    $rose(aresetn) |-> !command_mode && flow_output_line && !bvalid && !rvalid &&
      serial_rate_setting == 16'h0000;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not at reset values");
  property p_write_answer;
    s_wr_taken |-> ##2 bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response not on time");
  property p_read_answer;
    s_rd_taken |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data not on time");
  property p_write_busy;
    bvalid |-> !awready && !wready;
  endproperty
  a_write_busy: assert property (p_write_busy)
    else $error("write taken while response pending");
  property p_read_busy;
    rvalid |-> !arready;
  endproperty
  a_read_busy: assert property (p_read_busy)
    else $error("read taken while data pending");
  property p_b_release;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_release: assert property (p_b_release)
    else $error("write channel not released");
  property p_r_release;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_r_release: assert property (p_r_release)
    else $error("read channel not released");
  // the shortest legal trailing guard is two units
  property p_entry_quiet;
    $rose(command_mode) |-> quiet_q >= 2 * TICK_CYCLES;
  endproperty
  a_entry_quiet: assert property (p_entry_quiet)
    else $error("command mode entered without trailing silence");
  property p_rate_on_exit;
    $changed(serial_rate_setting) |-> $fell(command_mode);
  endproperty
  a_rate_on_exit: assert property (p_rate_on_exit)
    else $error("rate changed outside exit");
endmodule : cme_top_asserts

bind cme_top cme_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .serial_input_line_vld(serial_input_line_vld), .command_mode(command_mode),
  .flow_output_line(flow_output_line), .serial_rate_setting(serial_rate_setting)
);
`default_nettype wire

// >>> cme_host_model.sv
// host on the serial side: byte strobes and guard silences
// assumes its tasks are called just after a rising edge of aclk
`timescale 1ns/100ps
`default_nettype none

module cme_host_model
#(
  parameter int unsigned TICK_CYCLES = 4
)
(
  input  wire logic       aclk,     // module clock
  output var  logic       byte_vld, // one-cycle byte strobe
  output var  logic [7:0] byte_val  // byte value
);
  initial
  begin
    byte_vld = 1'b0;
    byte_val = 8'h00;
  end

  // between strobes the byte lines carry the inverse, so stale data never matches
  task automatic send(input logic [7:0] b);
    byte_vld <= 1'b1;
    byte_val <= b;
    @(posedge aclk);
    byte_vld <= 1'b0;
    byte_val <= ~b;
    @(posedge aclk);
  endtask : send

  task automatic quiet(input int units);
    repeat (units * TICK_CYCLES) @(posedge aclk);
  endtask : quiet
endmodule : cme_host_model
`default_nettype wire

// >>> cme_top_tb_top.sv
// self-checking bench for the command-mode entry block
// assumes design, host model and checker are compiled before it
`timescale 1ns/100ps
`default_nettype none

module cme_top_tb_top;
  localparam int unsigned TICK = 4;

  typedef struct packed {
    logic [7:0]  code;
    logic        wr;
    logic [15:0] param;
    logic [18:0] resp;
  } cme_row_type;

  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, rx_active = 1'b0, rx_addr_match = 1'b0;
  logic        clear_to_send = 1'b1, tx_active = 1'b0;
  logic [31:0] awaddr = 32'h00000000, wdata = 32'h00000000, araddr = 32'h00000000;
  logic [3:0]  wstrb = 4'hF;
  logic [2:0]  prot = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, ser_vld, flow_line, ind_line, cmd_mode;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  ser_byte;
  logic [15:0] rate;
  int          errors = 0;
  int          tests_run = 0;
  cme_row_type rows [16] = '{
    '{8'h04, 1'b0, 16'h0000, 19'h2000A}, '{8'h13, 1'b0, 16'h0000, 19'h1002B},
    '{8'h28, 1'b0, 16'h0000, 19'h10000}, '{8'h1F, 1'b0, 16'h0000, 19'h10000},
    '{8'h04, 1'b1, 16'h0003, 19'h20003}, '{8'h04, 1'b1, 16'h0001, 19'h40003},
    '{8'h04, 1'b0, 16'h0000, 19'h20003}, '{8'h05, 1'b1, 16'h0002, 19'h20002},
    '{8'h13, 1'b1, 16'h002A, 19'h1002A}, '{8'h13, 1'b1, 16'h001F, 19'h4002A},
    '{8'h13, 1'b1, 16'h0080, 19'h4002A}, '{8'h28, 1'b1, 16'h0005, 19'h40000},
    '{8'h1F, 1'b1, 16'h0005, 19'h40000}, '{8'h15, 1'b1, 16'h012C, 19'h2012B},
    '{8'h15, 1'b1, 16'h0006, 19'h20006}, '{8'h15, 1'b1, 16'hE100, 19'h2E883}};

  always #20 aclk = ~aclk;

  cme_top #(.TICK_CYCLES(TICK)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(prot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(prot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .serial_input_line_vld(ser_vld), .serial_input_line_byte(ser_byte),
    .rx_active(rx_active), .rx_addr_match(rx_addr_match), .clear_to_send(clear_to_send),
    .tx_active(tx_active), .indicator_output_line(ind_line), .flow_output_line(flow_line),
    .command_mode(cmd_mode), .serial_rate_setting(rate));
  cme_host_model #(.TICK_CYCLES(TICK)) host_u (
    .aclk(aclk), .byte_vld(ser_vld), .byte_val(ser_byte));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // the trailing edge keeps a following call from re-driving a strobe in the same step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    awvalid <= 1'b1;
    awaddr  <= {24'h000000, a};
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    arvalid <= 1'b1;
    araddr  <= {24'h000000, a};
    rready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask : axi_rd

  task automatic cmd(input logic [7:0] c, input logic wr, input logic [15:0] p,
                     output logic [31:0] d);
    logic [1:0] r;
    axi_wr(8'h00, {7'h00, wr, c, p}, r);
    axi_rd(8'h04, d, r);
  endtask : cmd

  task automatic attempt(input int lu, input logic [7:0] ch, input int tu,
                         input logic stray, input logic exp);
    host_u.quiet(lu);
    host_u.send(ch);
    host_u.quiet(tu);
    if (stray)
      host_u.send(8'h41);
    host_u.quiet(12);
    chk("mode", {31'h00000000, exp}, {31'h00000000, cmd_mode});
  endtask : attempt

  // bit c is the expected pin level for setting c under inputs p
  function automatic logic line_exp(input logic ind, input int c, input logic [1:0] p);
    logic [4:0] t;
    t = ind ? {p[0] & p[1], 1'b0, 1'b0, 1'b1, p[0]} : {1'b0, p[1], 1'b1, ~p[1], ~p[0]};
    return t[c];
  endfunction : line_exp

  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end

  initial
  begin
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("flow", 32'h00000000, {31'h00000000, flow_line});
    axi_rd(8'h0C, d, r);
    chk("config", 32'h2B000000, d);
    axi_rd(8'h10, d, r);
    chk("rresp", 32'h00000002, {30'h00000000, r});
    axi_wr(8'h04, 32'h00000000, r);
    chk("bresp", 32'h00000002, {30'h00000000, r});
    wstrb <= 4'h7;
    prot  <= 3'h2;
    axi_wr(8'h00, 32'h01040003, r);
    chk("bresp", 32'h00000002, {30'h00000000, r});
    wstrb <= 4'hF;
    cmd(8'h04, 1'b0, 16'h0000, d);
    chk("resp", 32'h00040000, d);
    host_u.send(8'h41);
    attempt(5, 8'h2B, 12, 1'b0, 1'b0);
    attempt(12, 8'h41, 12, 1'b0, 1'b0);
    attempt(12, 8'h2B, 5, 1'b1, 1'b0);
    attempt(12, 8'h2B, 12, 1'b0, 1'b1);
    axi_rd(8'h08, d, r);
    chk("status", 32'h00000008, d & 32'hFFFF000F);
    foreach (rows[i])
    begin
      cmd(rows[i].code, rows[i].wr, rows[i].param, d);
      m = rows[i].resp[18] ? 32'h0004FFFF : 32'h0007FFFF;
      chk("resp", {13'h0000, rows[i].resp} & m, d & m);
    end
    axi_rd(8'h00, d, r);
    chk("last", 32'h0115E100, d);
    for (int c = 0; c < 5; c++)
    begin
      cmd(8'h1F, 1'b1, 16'(c), d);
      cmd(8'h28, 1'b1, 16'(c), d);
      for (int p = 0; p < 4; p++)
      begin
        clear_to_send <= p[0];
        rx_active     <= p[0];
        tx_active     <= p[1];
        rx_addr_match <= p[1];
        repeat (3) @(posedge aclk);
        chk("flow", {31'h00000000, line_exp(1'b0, c, p[1:0])}, {31'h00000000, flow_line});
        chk("ind", {31'h00000000, line_exp(1'b1, c, p[1:0])}, {31'h00000000, ind_line});
      end
    end
    chk("rate", 32'h00000000, {16'h0000, rate});
    axi_wr(8'h00, {7'h00, 1'b1, 8'h09, 16'h0000}, r);
    chk("mode", 32'h00000000, {31'h00000000, cmd_mode});
    chk("rate", 32'h0000E883, {16'h0000, rate});
    attempt(4, 8'h2B, 3, 1'b0, 1'b0);
    attempt(4, 8'h2A, 3, 1'b0, 1'b1);
    cmd(8'h06, 1'b1, 16'h0003, d);
    host_u.quiet(1);
    chk("mode", 32'h00000001, {31'h00000000, cmd_mode});
    host_u.quiet(3);
    chk("mode", 32'h00000000, {31'h00000000, cmd_mode});
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(8'h0C, d, r);
    chk("config", 32'h2B000000, d);
    conclude();
  end
endmodule : cme_top_tb_top
`default_nettype wire
